//--- frs_host.sv
`timescale 1ns/1ps
`include "frs_cfg.svh"
module frs_host
    import frs_pkg::*;
#(
    parameter int unsigned SETTLE_CYC = `FRS_US_CYC(`FRS_SUPPLY_SETTLE_US),
    parameter int unsigned POWERON_REC_CYC = `FRS_US_CYC(`FRS_POWERON_RECOVERY_US),
    parameter int unsigned REC_DECODE_CYC = `FRS_US_CYC(`FRS_REC_DECODE_US),
    parameter int unsigned REC_READ_CYC = `FRS_US_CYC(`FRS_REC_READ_US),
    parameter int unsigned REC_PROG_CYC = `FRS_US_CYC(`FRS_REC_PROG_US),
    parameter int unsigned REC_SMALL_CYC = `FRS_MS_CYC(`FRS_REC_SMALL_MS),
    parameter int unsigned REC_BLOCK_CYC = `FRS_MS_CYC(`FRS_REC_BLOCK_MS),
    parameter int unsigned REC_CHIP_CYC = `FRS_MS_CYC(`FRS_REC_CHIP_MS),
    parameter int unsigned REC_STWR_CYC = `FRS_MS_CYC(`FRS_REC_STWR_MS)
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Link
    frs_link_if.host lk,
    // Supply monitor
    input wire logic supply_ok,
    // User command port
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_byte,
    input wire logic hw_reset_req,
    input wire logic sw_reset_req,
    output logic cmd_ready,
    // Status readback
    output logic stat_valid,
    output logic [7:0] stat_byte
);
    localparam int unsigned RST_LOW_CYC = `FRS_US_CYC(`FRS_RESET_LOW_MIN_US);
    localparam int unsigned GAP_CYC = `FRS_US_CYC(`FRS_RESET_TO_SELECT_GAP_US);
    localparam frs_host_s_t HOST_RST = '{
        st: FRS_H_POWERUP,
        last_op: FRS_OP_NONE,
        rst_n: 1'b1,
        cs_n: 1'b1,
        default: '0
    };

    frs_host_s_t s_ff;
    frs_host_s_t nxt_s;

    // Recovery length for the operation caught by a reset
    function automatic logic [31:0] rec_cyc(input frs_op_t op);
        logic [31:0] r;
        r = 32'(REC_DECODE_CYC);
        case (op)
            FRS_OP_READ: r = 32'(REC_READ_CYC);
            FRS_OP_PROG: r = 32'(REC_PROG_CYC);
            FRS_OP_SMALL: r = 32'(REC_SMALL_CYC);
            FRS_OP_BLOCK: r = 32'(REC_BLOCK_CYC);
            FRS_OP_CHIP: r = 32'(REC_CHIP_CYC);
            FRS_OP_STWR: r = 32'(REC_STWR_CYC);
            default: r = 32'(REC_DECODE_CYC);
        endcase
        return r;
    endfunction

    // Which operation a command starts, none for the rest
    function automatic frs_op_t op_of(input logic [7:0] c);
        frs_op_t o;
        o = FRS_OP_NONE;
        if (c == `FRS_CMD_READ) begin
            o = FRS_OP_READ;
        end else if (c == `FRS_CMD_PROG) begin
            o = FRS_OP_PROG;
        end else if (c == `FRS_CMD_SMALL_ERASE) begin
            o = FRS_OP_SMALL;
        end else if (c == `FRS_CMD_BLOCK_ERASE) begin
            o = FRS_OP_BLOCK;
        end else if (c == `FRS_CMD_CHIP_ERASE) begin
            o = FRS_OP_CHIP;
        end else if (c == `FRS_CMD_STATUS_WRITE) begin
            o = FRS_OP_STWR;
        end
        return o;
    endfunction

    // Next state
    always_comb begin
        nxt_s = s_ff;
        nxt_s.stat_vld = 1'b0;
        if (!supply_ok) begin
            nxt_s = HOST_RST;
        end else begin
            case (s_ff.st)
                FRS_H_POWERUP: begin
                    nxt_s.cnt = s_ff.cnt + 32'd1;
                    if (s_ff.cnt >= 32'(SETTLE_CYC - 1)) begin
                        nxt_s.st = FRS_H_WAIT;
                        nxt_s.cnt = 32'd0;
                        nxt_s.lim = 32'(POWERON_REC_CYC);
                    end
                end
                FRS_H_WAIT: begin
                    nxt_s.cnt = s_ff.cnt + 32'd1;
                    if (s_ff.cnt >= s_ff.lim - 32'd1) begin
                        nxt_s.st = FRS_H_IDLE;
                        nxt_s.cnt = 32'd0;
                        nxt_s.last_op = FRS_OP_NONE;
                        nxt_s.ready = 1'b1;
                    end
                end
                FRS_H_IDLE: begin
                    if (hw_reset_req) begin
                        nxt_s.rst_n = 1'b0;
                        nxt_s.st = FRS_H_RST_LOW;
                        nxt_s.cnt = 32'd0;
                        nxt_s.ready = 1'b0;
                    end else if (sw_reset_req || cmd_valid) begin
                        // Arm goes first; execute follows from the gap state
                        nxt_s.sh = sw_reset_req ? `FRS_CMD_RESET_ARM : cmd_byte;
                        nxt_s.pend_exec = sw_reset_req;
                        nxt_s.is_rd = !sw_reset_req && cmd_byte == `FRS_CMD_STAT_RD;
                        if (!sw_reset_req && op_of(cmd_byte) != FRS_OP_NONE) begin
                            nxt_s.last_op = op_of(cmd_byte);
                        end
                        nxt_s.cs_n = 1'b0;
                        nxt_s.si = nxt_s.sh[7];
                        nxt_s.sh = {nxt_s.sh[6:0], 1'b0};
                        nxt_s.bitcnt = 3'd0;
                        nxt_s.st = FRS_H_SEND;
                        nxt_s.ready = 1'b0;
                    end
                end
                FRS_H_SEND: begin
                    if (s_ff.bitcnt == 3'd7) begin
                        nxt_s.bitcnt = 3'd0;
                        if (s_ff.is_rd) begin
                            nxt_s.st = FRS_H_RDSTAT;
                        end else begin
                            nxt_s.cs_n = 1'b1;
                            nxt_s.st = FRS_H_GAP;
                        end
                    end else begin
                        nxt_s.si = s_ff.sh[7];
                        nxt_s.sh = {s_ff.sh[6:0], 1'b0};
                        nxt_s.bitcnt = s_ff.bitcnt + 3'd1;
                    end
                end
                FRS_H_RDSTAT: begin
                    nxt_s.stat = {s_ff.stat[6:0], lk.so_line};
                    nxt_s.bitcnt = s_ff.bitcnt + 3'd1;
                    if (s_ff.bitcnt == 3'd7) begin
                        nxt_s.stat_vld = 1'b1;
                        nxt_s.cs_n = 1'b1;
                        nxt_s.st = FRS_H_GAP;
                        // Idle array means nothing left to recover from
                        if (!lk.so_line) begin
                            nxt_s.last_op = FRS_OP_NONE;
                        end
                    end
                end
                FRS_H_GAP: begin
                    if (s_ff.pend_exec) begin
                        nxt_s.sh = {`FRS_CMD_RESET_EXEC} << 1;
                        nxt_s.si = 1'b1;
                        nxt_s.cs_n = 1'b0;
                        nxt_s.pend_exec = 1'b0;
                        nxt_s.swr = 1'b1;
                        nxt_s.is_rd = 1'b0;
                        nxt_s.bitcnt = 3'd0;
                        nxt_s.st = FRS_H_SEND;
                    end else if (s_ff.swr) begin
                        nxt_s.swr = 1'b0;
                        nxt_s.st = FRS_H_WAIT;
                        nxt_s.cnt = 32'd0;
                        nxt_s.lim = rec_cyc(s_ff.last_op);
                    end else begin
                        nxt_s.st = FRS_H_IDLE;
                        nxt_s.ready = 1'b1;
                    end
                end
                FRS_H_RST_LOW: begin
                    nxt_s.cnt = s_ff.cnt + 32'd1;
                    if (s_ff.cnt >= 32'(RST_LOW_CYC - 1)) begin
                        nxt_s.rst_n = 1'b1;
                        nxt_s.st = FRS_H_WAIT;
                        nxt_s.cnt = 32'd0;
                        nxt_s.lim = rec_cyc(s_ff.last_op);
                        // pin release needs the select gap; soft reset leaves pin high
                        if (nxt_s.lim < 32'(GAP_CYC)) begin
                            nxt_s.lim = 32'(GAP_CYC);
                        end
                    end
                end
                default: begin
                    nxt_s = HOST_RST;
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            s_ff <= HOST_RST;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // Pins and user outputs straight from state
    assign lk.rst_n = s_ff.rst_n;
    assign lk.cs_n = s_ff.cs_n;
    assign lk.si = s_ff.si;
    assign cmd_ready = s_ff.ready;
    assign stat_valid = s_ff.stat_vld;
    assign stat_byte = s_ff.stat;
endmodule

//--- frs_cfg.svh
// Operation
// - Reset pin held low at least 10 us
// - Reset leaves standby, volatile bits at defaults
// - Reset aborts running program or erase
// - Data output undriven during reset cycle
// - Host waits 10 us before select
// - Power-on reset needs 35 us recovery
// - Decode or read interrupted: 40 us recovery
// - Program interrupted: 310 us recovery
// - Erase interrupted: 12, 25, 1000 ms
// - Status write interrupted: 40 ms recovery
// - Power-up enters standby, write latch cleared
// - Host keeps device deselected during power ramps
// - Below supply threshold: logic reset, commands ignored
// - Commands only after supply settle delay
// - Arm then execute; other command cancels arming
`ifndef FRS_CFG_SVH
`define FRS_CFG_SVH

// Clock rate and time conversion
`define FRS_CLK_MHZ 250
`define FRS_US_CYC(t) ((t) * `FRS_CLK_MHZ)
`define FRS_MS_CYC(t) ((t) * 1000 * `FRS_CLK_MHZ)

// Reset pin and power-up timing, microseconds
`define FRS_RESET_LOW_MIN_US 10
`define FRS_RESET_TO_SELECT_GAP_US 10
`define FRS_POWERON_RECOVERY_US 35
`define FRS_SUPPLY_SETTLE_US 800

// Recovery after interrupted operation
`define FRS_REC_DECODE_US 40
`define FRS_REC_READ_US 40
`define FRS_REC_PROG_US 310
`define FRS_REC_SMALL_MS 12
`define FRS_REC_BLOCK_MS 25
`define FRS_REC_CHIP_MS 1000
`define FRS_REC_STWR_MS 40

// Device self-timed operation length, cycles
`define FRS_OP_CYC 64

// Command codes
`define FRS_CMD_RESET_ARM 8'h66
`define FRS_CMD_RESET_EXEC 8'h99
`define FRS_CMD_WREN 8'h06
`define FRS_CMD_READ 8'h03
`define FRS_CMD_STAT_RD 8'h05
`define FRS_CMD_STATUS_WRITE 8'h01
`define FRS_CMD_PROG 8'h02
`define FRS_CMD_SMALL_ERASE 8'h20
`define FRS_CMD_BLOCK_ERASE 8'hd8
`define FRS_CMD_CHIP_ERASE 8'hc7
`define FRS_CMD_LOCK 8'h36

// Status byte field positions
`define FRS_ST_OP_IN_PROGRESS_BIT 0
`define FRS_ST_WLF_BIT 1
`define FRS_ST_LOCK_BIT 2

`endif

//--- frs_pkg.sv
package frs_pkg;

    typedef enum logic [2:0] {
        FRS_D_STANDBY = 3'b001,
        FRS_D_BUSY = 3'b010,
        FRS_D_RESET = 3'b100
    } frs_dev_st_t;

    typedef enum logic [6:0] {
        FRS_H_POWERUP = 7'b0000001,
        FRS_H_WAIT = 7'b0000010,
        FRS_H_IDLE = 7'b0000100,
        FRS_H_SEND = 7'b0001000,
        FRS_H_RDSTAT = 7'b0010000,
        FRS_H_GAP = 7'b0100000,
        FRS_H_RST_LOW = 7'b1000000
    } frs_host_st_t;

    typedef enum logic [2:0] {
        FRS_OP_NONE, FRS_OP_READ, FRS_OP_PROG, FRS_OP_SMALL,
        FRS_OP_BLOCK, FRS_OP_CHIP, FRS_OP_STWR
    } frs_op_t;

    typedef struct packed {
        frs_dev_st_t st;
        logic wlf;
        logic op_in_progress;
        logic lock;
        logic armed;
        logic [7:0] shreg;
        logic [2:0] bitcnt;
        logic rd_active;
        logic [7:0] so_sh;
        logic so;
        logic so_oe;
        logic [11:0] low_cnt;
        logic [15:0] op_cnt;
        logic aborted;
    } frs_dev_s_t;

    typedef struct packed {
        frs_host_st_t st;
        logic [31:0] cnt;
        logic [31:0] lim;
        logic [7:0] sh;
        logic [2:0] bitcnt;
        logic is_rd;
        logic pend_exec;
        logic swr;
        frs_op_t last_op;
        logic rst_n;
        logic cs_n;
        logic si;
        logic ready;
        logic [7:0] stat;
        logic stat_vld;
    } frs_host_s_t;

endpackage

//--- frs_link_if.sv
`timescale 1ns/1ps
interface frs_link_if;
    // Host driven pins
    logic rst_n;
    logic cs_n;
    logic si;
    // Device data output with its enable
    logic so;
    logic so_oe;
    // Resolved data line, pulled high when undriven
    logic so_line;

    assign so_line = so_oe ? so : 1'b1;

    modport dev (input rst_n, input cs_n, input si, output so, output so_oe);
    modport host (output rst_n, output cs_n, output si, input so_line);
endinterface

//--- frs_dev.sv
`timescale 1ns/1ps
`include "frs_cfg.svh"
module frs_dev
    import frs_pkg::*;
#(
    parameter int unsigned OP_CYC = `FRS_OP_CYC
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Link
    frs_link_if.dev lk,
    // Supply monitor
    input wire logic supply_ok,
    // Status view
    output logic standby,
    output logic write_latch_flag,
    output logic op_in_progress_flag,
    output logic lock_flag,
    output logic in_reset,
    output logic op_aborted
);
    localparam int unsigned RST_LOW_CYC = `FRS_US_CYC(`FRS_RESET_LOW_MIN_US);
    localparam frs_dev_s_t DEV_RST = '{st: FRS_D_STANDBY, default: '0};

    frs_dev_s_t s_ff;
    frs_dev_s_t nxt_s;
    logic [7:0] cmd;

    // Incoming command byte including this cycle's bit
    assign cmd = {s_ff.shreg[6:0], lk.si};

    // Next state
    always_comb begin
        nxt_s = s_ff;
        nxt_s.aborted = 1'b0;
        if (!supply_ok) begin
            nxt_s = DEV_RST;
        end else if (!lk.rst_n) begin
            nxt_s.so_oe = 1'b0;
            nxt_s.bitcnt = 3'd0;
            nxt_s.rd_active = 1'b0;
            if (s_ff.low_cnt != 12'(RST_LOW_CYC - 1)) begin
                nxt_s.low_cnt = s_ff.low_cnt + 12'd1;
            end else begin
                nxt_s = DEV_RST;
                nxt_s.st = FRS_D_RESET;
                nxt_s.low_cnt = s_ff.low_cnt;
                nxt_s.aborted = s_ff.op_in_progress;
            end
        end else begin
            nxt_s.low_cnt = 12'd0;
            if (s_ff.st == FRS_D_RESET) begin
                nxt_s.st = FRS_D_STANDBY;
            end
            // Self-timed operation
            if (s_ff.st == FRS_D_BUSY) begin
                if (s_ff.op_cnt == 16'd0) begin
                    nxt_s.op_in_progress = 1'b0;
                    nxt_s.wlf = 1'b0;
                    nxt_s.st = FRS_D_STANDBY;
                end else begin
                    nxt_s.op_cnt = s_ff.op_cnt - 16'd1;
                end
            end
            if (lk.cs_n) begin
                nxt_s.bitcnt = 3'd0;
                nxt_s.rd_active = 1'b0;
                nxt_s.so_oe = 1'b0;
            end else if (s_ff.rd_active) begin
                nxt_s.so = s_ff.so_sh[7];
                nxt_s.so_sh = {s_ff.so_sh[6:0], 1'b0};
            end else begin
                nxt_s.shreg = cmd;
                nxt_s.bitcnt = s_ff.bitcnt + 3'd1;
                if (s_ff.bitcnt == 3'd7) begin
                    nxt_s.armed = (cmd == `FRS_CMD_RESET_ARM);
                    if (cmd == `FRS_CMD_RESET_EXEC && s_ff.armed) begin
                        nxt_s = DEV_RST;
                        nxt_s.aborted = s_ff.op_in_progress;
                    end else if (cmd == `FRS_CMD_STAT_RD) begin
                        nxt_s.rd_active = 1'b1;
                        nxt_s.so_oe = 1'b1;
                        nxt_s.so = s_ff.lock & (`FRS_ST_LOCK_BIT == 7);
                        nxt_s.so_sh = 8'h00;
                        nxt_s.so_sh[`FRS_ST_OP_IN_PROGRESS_BIT] = s_ff.op_in_progress;
                        nxt_s.so_sh[`FRS_ST_WLF_BIT] = s_ff.wlf;
                        nxt_s.so_sh[`FRS_ST_LOCK_BIT] = s_ff.lock;
                        nxt_s.so = nxt_s.so_sh[7];
                        nxt_s.so_sh = {nxt_s.so_sh[6:0], 1'b0};
                    end else if (cmd == `FRS_CMD_WREN) begin
                        nxt_s.wlf = ~s_ff.op_in_progress;
                    end else if (cmd == `FRS_CMD_LOCK) begin
                        nxt_s.lock = 1'b1;
                    end else if ((cmd == `FRS_CMD_PROG || cmd == `FRS_CMD_SMALL_ERASE ||
                                  cmd == `FRS_CMD_BLOCK_ERASE ||
                                  cmd == `FRS_CMD_CHIP_ERASE ||
                                  cmd == `FRS_CMD_STATUS_WRITE) &&
                                 s_ff.wlf && !s_ff.op_in_progress) begin
                        // Writes need the latch and an idle array
                        nxt_s.op_in_progress = 1'b1;
                        nxt_s.st = FRS_D_BUSY;
                        nxt_s.op_cnt = 16'(OP_CYC);
                    end
                end
            end
        end
    end

    // State register; power-up standby, latch clear
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            s_ff <= DEV_RST;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // Outputs straight from state
    assign lk.so = s_ff.so;
    assign lk.so_oe = s_ff.so_oe;
    assign standby = (s_ff.st == FRS_D_STANDBY);
    assign write_latch_flag = s_ff.wlf;
    assign op_in_progress_flag = s_ff.op_in_progress;
    assign lock_flag = s_ff.lock;
    assign in_reset = (s_ff.st == FRS_D_RESET);
    assign op_aborted = s_ff.aborted;
endmodule

//--- frs_link_sva.sv
`timescale 1ns/1ps
`include "frs_cfg.svh"
module frs_link_sva #(
    parameter int unsigned SETTLE_CYC = 20,
    parameter int unsigned POWERON_REC_CYC = 30
) (
    // Clock, reset and supply
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic supply_ok,
    // Link signals
    input wire logic rst_n,
    input wire logic cs_n,
    input wire logic si,
    input wire logic so,
    input wire logic so_oe,
    input wire logic so_line
);
    localparam int LOW_CYC = `FRS_US_CYC(`FRS_RESET_LOW_MIN_US);
    localparam int GAP_CYC = `FRS_US_CYC(`FRS_RESET_TO_SELECT_GAP_US);
    logic [15:0] low_cnt_ff;
    logic [15:0] gap_cnt_ff;
    logic [15:0] por_cnt_ff;
    logic [7:0] sh_ff;
    logic [7:0] prev_ff;
    logic [2:0] bcnt_ff;
    logic pulsed_ff;
    logic done;
    logic [7:0] val;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);

    // Byte seen on the wire this edge
    assign done = rst_n && !cs_n && bcnt_ff == 3'h7;
    assign val = {sh_ff[6:0], si};

    // Gap and power-on counters saturate so a long idle stretch never wraps back to a small value
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            low_cnt_ff <= 16'h0;
            gap_cnt_ff <= 16'h0;
            por_cnt_ff <= 16'h0;
            sh_ff <= 8'h0;
            prev_ff <= 8'h0;
            bcnt_ff <= 3'h0;
            pulsed_ff <= 1'b0;
        end else begin
            low_cnt_ff <= rst_n ? 16'h0 : low_cnt_ff + 16'h1;
            gap_cnt_ff <= !rst_n ? 16'h0 : (&gap_cnt_ff) ? gap_cnt_ff : gap_cnt_ff + 16'h1;
            por_cnt_ff <= !supply_ok ? 16'h0 : (&por_cnt_ff) ? por_cnt_ff : por_cnt_ff + 16'h1;
            pulsed_ff <= pulsed_ff | !rst_n;
            if (cs_n) begin
                bcnt_ff <= 3'h0;
            end else if (rst_n) begin
                sh_ff <= val;
                bcnt_ff <= bcnt_ff + 3'h1;
                if (done) begin
                    prev_ff <= val;
                end
            end
        end
    end

    sequence s_stat_byte;
        done && val == `FRS_CMD_STAT_RD;
    endsequence
    sequence s_exec_byte;
        done && val == `FRS_CMD_RESET_EXEC;
    endsequence

    a_reset_low_width: assert property ($rose(rst_n) |-> low_cnt_ff >= LOW_CYC)
        else $error("reset pin pulse too short");
    a_so_off_reset: assert property (!rst_n |=> !so_oe && so_line)
        else $error("data output driven during reset");
    a_select_after_gap: assert property ($fell(cs_n) && pulsed_ff |-> gap_cnt_ff >= GAP_CYC)
        else $error("select too soon after reset release");
    a_no_select_reset: assert property (!rst_n |-> cs_n)
        else $error("select during reset pulse");
    a_poweron_quiet: assert property ($fell(cs_n) |-> por_cnt_ff >= SETTLE_CYC + POWERON_REC_CYC)
        else $error("select before power-on recovery");
    a_supply_deselect: assert property (!supply_ok |-> cs_n && rst_n)
        else $error("device selected while supply low");
    a_arm_then_exec: assert property (s_exec_byte |-> prev_ff == `FRS_CMD_RESET_ARM)
        else $error("reset execute without arm");
    a_status_drive: assert property (s_stat_byte |=> so_oe && so == 1'b0)
        else $error("status answer missing");
    a_oe_deselect: assert property (cs_n ##1 cs_n |-> !so_oe)
        else $error("data output left driven after deselect");
endmodule

//--- tb_top.sv
`timescale 1ns/1ps
`include "frs_cfg.svh"
module tb_top;
    localparam int SETTLE = 20;
    localparam int POR_REC = 30;
    localparam int LOW_CYC = `FRS_US_CYC(`FRS_RESET_LOW_MIN_US);
    // Short stand-in recoveries keep the run brief; each stays distinct
    localparam int REC_DEC = 40;
    localparam int REC_RD = 50;
    localparam int REC_PRG = 60;
    localparam int REC_SML = 70;
    localparam int REC_BLK = 80;
    localparam int REC_CHP = 90;
    localparam int REC_STW = 100;
    localparam int OP_CYC = 64;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic supply_ok = 1'b1;
    logic cmd_valid = 1'b0;
    logic hw_reset_req = 1'b0;
    logic sw_reset_req = 1'b0;
    logic [7:0] cmd_byte = 8'h00;
    logic [7:0] stat_byte;
    logic cmd_ready, stat_valid, standby, write_latch_flag, op_in_progress_flag;
    logic lock_flag, in_reset, op_aborted;
    int errors = 0;
    int compares = 0;
    int low_run = 0;
    int aborts = 0;
    int hiz_bad = 0;
    int in_rst = 0;

    frs_link_if lk_if();
    frs_host #(.SETTLE_CYC(SETTLE), .POWERON_REC_CYC(POR_REC), .REC_DECODE_CYC(REC_DEC),
        .REC_READ_CYC(REC_RD), .REC_PROG_CYC(REC_PRG), .REC_SMALL_CYC(REC_SML),
        .REC_BLOCK_CYC(REC_BLK), .REC_CHIP_CYC(REC_CHP),
        .REC_STWR_CYC(REC_STW)) frs_host_inst (.sys_clk(sys_clk),
        .reset(reset), .lk(lk_if), .supply_ok(supply_ok), .cmd_valid(cmd_valid),
        .cmd_byte(cmd_byte), .hw_reset_req(hw_reset_req), .sw_reset_req(sw_reset_req),
        .cmd_ready(cmd_ready), .stat_valid(stat_valid), .stat_byte(stat_byte));
    frs_dev #(.OP_CYC(OP_CYC)) frs_dev_inst (.sys_clk(sys_clk), .reset(reset), .lk(lk_if),
        .supply_ok(supply_ok), .standby(standby), .write_latch_flag(write_latch_flag),
        .op_in_progress_flag(op_in_progress_flag), .lock_flag(lock_flag),
        .in_reset(in_reset), .op_aborted(op_aborted));
    frs_link_sva #(.SETTLE_CYC(SETTLE), .POWERON_REC_CYC(POR_REC)) frs_link_sva_inst (
        .sys_clk(sys_clk), .reset(reset), .supply_ok(supply_ok), .rst_n(lk_if.rst_n),
        .cs_n(lk_if.cs_n), .si(lk_if.si), .so(lk_if.so), .so_oe(lk_if.so_oe),
        .so_line(lk_if.so_line));

    // 4 ns clock
    initial begin
        forever #2 sys_clk = ~sys_clk;
    end

    // Mid-cycle monitors, clear of the launching edge
    always @(negedge sys_clk) begin
        if (op_aborted === 1'b1) aborts++;
        if (in_reset === 1'b1 && lk_if.so_oe !== 1'b0) hiz_bad++;
        if (lk_if.rst_n === 1'b0) low_run++;
        if (in_reset === 1'b1) in_rst++;
    end

    task automatic note(input bit bad, input string what);
        compares++;
        if (bad) begin
            errors++;
            $display("wrong value at %0t: %s", $time, what);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        note(got !== exp, $sformatf("flag %b not %b", got, exp));
    endtask
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        note(got !== exp, $sformatf("byte %h not %h", got, exp));
    endtask
    task automatic chk_cnt(input int got, input int lo, input int hi);
        note(got < lo || got > hi, $sformatf("count %0d outside %0d..%0d", got, lo, hi));
    endtask

    // Bounded wait for the host to accept; returns cycles waited
    task automatic wait_ready(output int n);
        n = 0;
        while (cmd_ready !== 1'b1 && n < 20000) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        if (n >= 20000) note(1'b1, "host never ready");
    endtask

    // Request held until the edge that takes it; kind 0 command, 1 pin, 2 soft reset
    task automatic issue(input logic [1:0] kind, input logic [7:0] b);
        int n;
        wait_ready(n);
        cmd_byte = b;
        cmd_valid = kind == 2'h0;
        hw_reset_req = kind == 2'h1;
        sw_reset_req = kind == 2'h2;
        @(posedge sys_clk);
        #1;
        cmd_valid = 1'b0;
        hw_reset_req = 1'b0;
        sw_reset_req = 1'b0;
    endtask

    task automatic read_stat(input logic [7:0] exp);
        int n;
        issue(2'h0, `FRS_CMD_STAT_RD);
        n = 0;
        while (stat_valid !== 1'b1 && n < 100) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        if (n >= 100) note(1'b1, "status never valid");
        chk_byte(stat_byte, exp);
    endtask

    task automatic t_powerup();
        int n;
        chk_bit(standby, 1'b1);
        chk_bit(write_latch_flag, 1'b0);
        wait_ready(n);
        chk_cnt(n, SETTLE + POR_REC, SETTLE + POR_REC);
    endtask

    // pin reset, idle with lock set or mid-program
    task automatic t_hw_reset(input logic busy);
        int n;
        if (busy) begin
            issue(2'h0, `FRS_CMD_WREN);
            issue(2'h0, `FRS_CMD_PROG);
        end else begin
            issue(2'h0, `FRS_CMD_LOCK);
        end
        wait_ready(n);
        chk_bit(op_in_progress_flag, busy);
        chk_bit(lock_flag, !busy);
        aborts = 0;
        low_run = 0;
        hiz_bad = 0;
        in_rst = 0;
        issue(2'h1, 8'h00);
        wait_ready(n);
        chk_cnt(low_run, LOW_CYC, LOW_CYC + 1);
        chk_cnt(n, 2 * LOW_CYC, 2 * LOW_CYC + 10);
        chk_cnt(aborts, busy, busy);
        chk_cnt(hiz_bad, 0, 0);
        chk_cnt(in_rst, 1, 1);
        chk_bit(standby, 1'b1);
        chk_bit(lock_flag, 1'b0);
        chk_bit(op_in_progress_flag, 1'b0);
        read_stat(8'h00);
    endtask

    // soft reset after each kind of operation
    task automatic t_sw_reset();
        logic [7:0] ops [6] = '{`FRS_CMD_PROG, `FRS_CMD_SMALL_ERASE, `FRS_CMD_BLOCK_ERASE,
            `FRS_CMD_CHIP_ERASE, `FRS_CMD_STATUS_WRITE, `FRS_CMD_READ};
        int rec [7] = '{REC_PRG, REC_SML, REC_BLK, REC_CHP, REC_STW, REC_RD, REC_DEC};
        int n;
        for (int i = 0; i < 7; i++) begin
            if (i < 5) issue(2'h0, `FRS_CMD_WREN);
            if (i < 6) issue(2'h0, ops[i]);
            aborts = 0;
            issue(2'h2, 8'h00);
            // Two bytes with their gaps come before the recovery wait
            wait_ready(n);
            chk_cnt(n, rec[i] + 18, rec[i] + 24);
            chk_cnt(aborts, i < 5, i < 5);
            chk_bit(write_latch_flag, 1'b0);
            chk_bit(op_in_progress_flag, 1'b0);
        end
    endtask

    // supply dip clears state and restarts the settle delay
    task automatic t_supply();
        int n;
        issue(2'h0, `FRS_CMD_WREN);
        wait_ready(n);
        chk_bit(write_latch_flag, 1'b1);
        supply_ok = 1'b0;
        repeat (3) @(posedge sys_clk);
        #1;
        chk_bit(write_latch_flag, 1'b0);
        chk_bit(cmd_ready, 1'b0);
        supply_ok = 1'b1;
        wait_ready(n);
        chk_cnt(n, SETTLE + POR_REC, SETTLE + POR_REC);
        read_stat(8'h00);
    endtask

    task automatic close_out();
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Watchdog at about three times the expected run
    initial begin
        #150000;
        note(1'b1, "watchdog expired");
        close_out();
    end

    initial begin
        repeat (2) @(posedge sys_clk);
        #1;
        reset = 1'b0;
        t_powerup();
        t_hw_reset(1'b0);
        t_hw_reset(1'b1);
        t_sw_reset();
        t_supply();
        close_out();
    end
endmodule
